// File: rtl/io_output_tristate_control.sv
// I/O cell output path, global high-impedance net and boundary-scan port
`timescale 1ns/1ps
`default_nettype none

module io_output_tristate_control
#(
    parameter int NUM_CELLS = io_otc_pkg::CELLS_DEFAULT
)
(
    // Clock, reset, enable
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Fabric side of each io_cell
    input  wire logic [NUM_CELLS-1:0]   userOut,
    input  wire logic [NUM_CELLS-1:0]   userHiz,
    // Pads
    input  wire logic [NUM_CELLS-1:0]   padIn,
    output logic [NUM_CELLS-1:0]        padOut,
    output logic [NUM_CELLS-1:0]        padOe,
    output logic [NUM_CELLS-1:0]        padFast,
    // Global high-impedance net sources
    input  wire logic                   hizNetPin,
    input  wire logic                   hizNetNode,
    // Test pins
    input  wire logic                   tckPin,
    input  wire logic                   tmsPin,
    input  wire logic                   tdiPin,
    output logic                        tdoPin,
    output logic                        tdoOe,
    // User instruction hooks
    input  wire logic                   userTdo1,
    input  wire logic                   userTdo2,
    output logic                        user1Sel,
    output logic                        user2Sel,
    output logic                        userShift
);

    localparam int CHAIN = io_otc_pkg::BITS_PER_CELL * NUM_CELLS;

    generate
        if (NUM_CELLS < 1 || NUM_CELLS > io_otc_pkg::MAX_CELLS)
        begin : g_bad
            $error("NUM_CELLS out of range");
        end
    endgenerate

    logic [io_otc_pkg::CTRL_WIDTH-1:0] ctrl_ff;
    logic [NUM_CELLS-1:0]   outInvert_ff;
    logic [NUM_CELLS-1:0]   hizInvert_ff;
    logic [NUM_CELLS-1:0]   fastSel_ff;
    logic                   activated_ff;
    logic                   startupDone_ff;
    logic [CHAIN-1:0]       bsr_ff;
    logic [CHAIN-1:0]       capVec;
    logic [NUM_CELLS-1:0]   updT_ff;
    logic [NUM_CELLS-1:0]   updO_ff;
    logic                   bypass_ff;
    logic [31:0]            rdData;
    logic                   hit;
    logic                   access;
    logic                   bscanOn;
    logic                   extest;
    logic                   hizNetActive;
    logic                   scanIns;
    io_otc_pkg::tap_ctl_t   tapCtl;

    assign bscanOn = ctrl_ff[io_otc_pkg::CTRL_BSCAN_BIT];
    assign extest  = bscanOn && tapCtl.instr == io_otc_pkg::INS_EXTEST;
    assign scanIns = tapCtl.instr == io_otc_pkg::INS_EXTEST
                  || tapCtl.instr == io_otc_pkg::INS_SAMPLE;
    assign access  = psel & penable;

    // Global net source select
    assign hizNetActive = ctrl_ff[io_otc_pkg::CTRL_HIZ_PIN]
                        ? (hizNetPin ^ ctrl_ff[io_otc_pkg::CTRL_HIZ_INV]) : hizNetNode;

    // Test pins are claimed only with the scan option
    tap_controller u_tap
    (
        .mclk   (mclk),
        .rst    (rst),
        .ce     (ce),
        .tckIn  (bscanOn & tckPin),
        .tmsIn  (~bscanOn | tmsPin),
        .tdiIn  (tdiPin),
        .tapCtl (tapCtl)
    );

    // Register read mux
    always_comb
    begin
        hit    = 1'b1;
        rdData = 32'h0000_0000;
        case (paddr)
            io_otc_pkg::CTRL_OFS:    rdData = 32'(ctrl_ff);
            io_otc_pkg::OUT_INV_OFS: rdData = 32'(outInvert_ff);
            io_otc_pkg::HIZ_INV_OFS: rdData = 32'(hizInvert_ff);
            io_otc_pkg::FAST_OFS:    rdData = 32'(fastSel_ff);
            io_otc_pkg::STATUS_OFS:
            begin
                rdData[io_otc_pkg::STAT_ACTIVE_BIT] = activated_ff;
                rdData[io_otc_pkg::STAT_START_BIT]  = startupDone_ff;
                rdData[io_otc_pkg::STAT_EXTEST_BIT] = extest;
                rdData[io_otc_pkg::STAT_IR_LSB +: 3] = tapCtl.instr;
            end
            default: hit = 1'b0;
        endcase
    end

    // APB answer: one wait state
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready <= access & ~pready;
            if (access & ~pready)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rdData;
                pslverr <= ~hit | (pwrite && paddr == io_otc_pkg::STATUS_OFS);
            end
        end
    end

    // Configuration registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_ff      <= io_otc_pkg::CTRL_RESET;
            outInvert_ff <= '0;
            hizInvert_ff <= '0;
            fastSel_ff   <= '0;
        end
        else if (ce && access && pready && pwrite)
        begin
            case (paddr)
                io_otc_pkg::CTRL_OFS:    ctrl_ff <= pwdata[io_otc_pkg::CTRL_WIDTH-1:0];
                io_otc_pkg::OUT_INV_OFS: outInvert_ff <= pwdata[NUM_CELLS-1:0];
                io_otc_pkg::HIZ_INV_OFS: hizInvert_ff <= pwdata[NUM_CELLS-1:0];
                io_otc_pkg::FAST_OFS:    fastSel_ff <= pwdata[NUM_CELLS-1:0];
                default:                 ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // Soft start-up tracking
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            activated_ff   <= 1'b0;
            startupDone_ff <= 1'b0;
        end
        else if (ce)
        begin
            activated_ff   <= ctrl_ff[io_otc_pkg::CTRL_CFG_DONE];
            startupDone_ff <= activated_ff;
        end
    end

    // Pad drivers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            padOut  <= '0;
            padOe   <= '0;
            padFast <= '0;
        end
        else if (ce)
        begin
            if (extest)
            begin
                padOut <= updO_ff;
                padOe  <= ~updT_ff;
            end
            else
            begin
                padOut <= userOut ^ outInvert_ff;
                padOe  <= (activated_ff && !hizNetActive)
                        ? ~(userHiz ^ hizInvert_ff) : '0;
            end
            padFast <= startupDone_ff ? fastSel_ff : '0;
        end
    end

    // Three capture cells per io_cell, tristate nearest the output end
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CELLS; gi++)
        begin : g_cell
            assign capVec[gi*3 + io_otc_pkg::CELL_T_POS] = ~padOe[gi];
            assign capVec[gi*3 + io_otc_pkg::CELL_O_POS] = padOut[gi];
            assign capVec[gi*3 + io_otc_pkg::CELL_I_POS] = padIn[gi];
        end
    endgenerate

    // Boundary register and update cells
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bsr_ff  <= '0;
            updT_ff <= '1;
            updO_ff <= '0;
        end
        else if (ce && tapCtl.tckRise && scanIns)
        begin
            if (tapCtl.captureDr)
                bsr_ff <= capVec;
            else if (tapCtl.shiftDr)
                bsr_ff <= {tdiPin, bsr_ff[CHAIN-1:1]};
            else if (tapCtl.updateDr)
            begin
                for (int k = 0; k < NUM_CELLS; k++)
                begin
                    updT_ff[k] <= bsr_ff[k*3 + io_otc_pkg::CELL_T_POS];
                    updO_ff[k] <= bsr_ff[k*3 + io_otc_pkg::CELL_O_POS];
                end
            end
        end
    end

    // Bypass cell
    always_ff @(posedge mclk)
    begin
        if (rst)
            bypass_ff <= 1'b0;
        else if (ce && tapCtl.tckRise && tapCtl.captureDr)
            bypass_ff <= 1'b0;
        else if (ce && tapCtl.tckRise && tapCtl.shiftDr)
            bypass_ff <= tdiPin;
    end

    // Test data out, changes on the falling test clock
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tdoPin <= 1'b0;
            tdoOe  <= 1'b0;
        end
        else if (ce)
        begin
            tdoOe <= bscanOn;
            if (tapCtl.tckFall && tapCtl.shiftIr)
                tdoPin <= tapCtl.irTdo;
            else if (tapCtl.tckFall && tapCtl.shiftDr)
            begin
                case (tapCtl.instr)
                    io_otc_pkg::INS_EXTEST: tdoPin <= bsr_ff[0];
                    io_otc_pkg::INS_SAMPLE: tdoPin <= bsr_ff[0];
                    io_otc_pkg::INS_USER1:  tdoPin <= userTdo1;
                    io_otc_pkg::INS_USER2:  tdoPin <= userTdo2;
                    default:                tdoPin <= bypass_ff;
                endcase
            end
        end
    end

    // User instruction decodes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            user1Sel  <= 1'b0;
            user2Sel  <= 1'b0;
            userShift <= 1'b0;
        end
        else if (ce)
        begin
            user1Sel  <= bscanOn && tapCtl.instr == io_otc_pkg::INS_USER1;
            user2Sel  <= bscanOn && tapCtl.instr == io_otc_pkg::INS_USER2;
            userShift <= tapCtl.tckRise && tapCtl.shiftDr
                      && (tapCtl.instr == io_otc_pkg::INS_USER1
                      || tapCtl.instr == io_otc_pkg::INS_USER2);
        end
    end

    AST_OUT_DATA: assert property (@(posedge mclk) disable iff (rst)
        (ce && !extest) |=> padOut == $past(userOut ^ outInvert_ff))
        else $error("pad data does not follow user data");

    AST_HIZ_CTRL: assert property (@(posedge mclk) disable iff (rst)
        (ce && !extest && activated_ff && !hizNetActive)
        |=> padOe == $past(~(userHiz ^ hizInvert_ff)))
        else $error("pad enable does not follow tristate input");

    AST_GLOBAL_HIZ: assert property (@(posedge mclk) disable iff (rst)
        (ce && hizNetActive && !extest) |=> padOe == '0)
        else $error("global net did not float outputs");

    AST_EXTEST_PADS: assert property (@(posedge mclk) disable iff (rst)
        (ce && extest) |=> (padOe == $past(~updT_ff) && padOut == $past(updO_ff)))
        else $error("extest pads not from update cells");

    AST_SOFT_START: assert property (@(posedge mclk) disable iff (rst)
        (ce && !startupDone_ff) |=> padFast == '0)
        else $error("fast slew before start-up finished");

    AST_OWN_SLEW: assert property (@(posedge mclk) disable iff (rst)
        (ce && startupDone_ff) |=> padFast == $past(fastSel_ff))
        else $error("slew not per-cell after start-up");

    AST_START_SEQ: assert property (@(posedge mclk) disable iff (rst)
        (ce && $rose(activated_ff)) |-> !startupDone_ff ##1 (!ce || startupDone_ff))
        else $error("start-up sequence wrong");

    AST_TDO_OWNED: assert property (@(posedge mclk) disable iff (rst)
        ce |=> tdoOe == $past(bscanOn))
        else $error("test output not claimed by scan option");

    AST_BYPASS_BIT: assert property (@(posedge mclk) disable iff (rst)
        (ce && tapCtl.tckRise && tapCtl.shiftDr) |=> bypass_ff == $past(tdiPin))
        else $error("bypass cell did not shift");

    AST_USER_SEL: assert property (@(posedge mclk) disable iff (rst)
        ce |=> user1Sel == $past(bscanOn && tapCtl.instr == io_otc_pkg::INS_USER1))
        else $error("user select decode wrong");

endmodule

`default_nettype wire

// File: rtl/io_otc_pkg.sv
// Shared constants and types for the I/O output and test-port block
package io_otc_pkg;

    // APB register byte offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  OUT_INV_OFS     = 8'h04;
    localparam logic [7:0]  HIZ_INV_OFS     = 8'h08;
    localparam logic [7:0]  FAST_OFS        = 8'h0C;
    localparam logic [7:0]  STATUS_OFS      = 8'h10;

    // Control register fields
    localparam int          CTRL_BSCAN_BIT  = 0;
    localparam int          CTRL_HIZ_INV    = 1;
    localparam int          CTRL_HIZ_PIN    = 2;
    localparam int          CTRL_CFG_DONE   = 3;
    localparam int          CTRL_WIDTH      = 4;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;

    // Status register fields
    localparam int          STAT_ACTIVE_BIT = 0;
    localparam int          STAT_START_BIT  = 1;
    localparam int          STAT_EXTEST_BIT = 2;
    localparam int          STAT_IR_LSB     = 4;

    // Limits
    localparam int          MAX_CELLS       = 32;
    localparam int          CELLS_DEFAULT   = 8;
    localparam int          BITS_PER_CELL   = 3;
    localparam int          CELL_T_POS      = 0;
    localparam int          CELL_O_POS      = 1;
    localparam int          CELL_I_POS      = 2;

    // Instruction codes
    localparam logic [2:0]  INS_EXTEST      = 3'h0;
    localparam logic [2:0]  INS_SAMPLE      = 3'h1;
    localparam logic [2:0]  INS_USER1       = 3'h2;
    localparam logic [2:0]  INS_USER2       = 3'h3;
    localparam logic [2:0]  INS_BYPASS      = 3'h7;
    localparam logic [2:0]  IR_CAPTURE_VAL  = 3'h1;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef struct packed {
        logic       tckRise;
        logic       tckFall;
        logic       captureDr;
        logic       shiftDr;
        logic       updateDr;
        logic       shiftIr;
        logic [2:0] instr;
        logic       irTdo;
    } tap_ctl_t;

endpackage

// File: rtl/tap_controller.sv
// Test access port state machine and instruction register
`timescale 1ns/1ps
`default_nettype none

module tap_controller
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // Test pins, sampled on mclk
    input  wire logic                   tckIn,
    input  wire logic                   tmsIn,
    input  wire logic                   tdiIn,
    // Decoded controls
    output io_otc_pkg::tap_ctl_t        tapCtl
);

    io_otc_pkg::tap_state_t state_ff;
    io_otc_pkg::tap_state_t nxt_state;
    logic                   tckPrev_ff;
    logic [2:0]             irShift_ff;
    logic [2:0]             ir_ff;
    logic                   rise;

    assign rise = tckIn & ~tckPrev_ff;

    always_ff @(posedge mclk)
    begin
        if (rst)
            tckPrev_ff <= 1'b0;
        else if (ce)
            tckPrev_ff <= tckIn;
    end

    // Sixteen-state walk
    always_comb
    begin
        case (state_ff)
            io_otc_pkg::TLR:    nxt_state = tmsIn ? io_otc_pkg::TLR    : io_otc_pkg::RTI;
            io_otc_pkg::RTI:    nxt_state = tmsIn ? io_otc_pkg::SEL_DR : io_otc_pkg::RTI;
            io_otc_pkg::SEL_DR: nxt_state = tmsIn ? io_otc_pkg::SEL_IR : io_otc_pkg::CAP_DR;
            io_otc_pkg::CAP_DR: nxt_state = tmsIn ? io_otc_pkg::EX1_DR : io_otc_pkg::SH_DR;
            io_otc_pkg::SH_DR:  nxt_state = tmsIn ? io_otc_pkg::EX1_DR : io_otc_pkg::SH_DR;
            io_otc_pkg::EX1_DR: nxt_state = tmsIn ? io_otc_pkg::UPD_DR : io_otc_pkg::PAU_DR;
            io_otc_pkg::PAU_DR: nxt_state = tmsIn ? io_otc_pkg::EX2_DR : io_otc_pkg::PAU_DR;
            io_otc_pkg::EX2_DR: nxt_state = tmsIn ? io_otc_pkg::UPD_DR : io_otc_pkg::SH_DR;
            io_otc_pkg::UPD_DR: nxt_state = tmsIn ? io_otc_pkg::SEL_DR : io_otc_pkg::RTI;
            io_otc_pkg::SEL_IR: nxt_state = tmsIn ? io_otc_pkg::TLR    : io_otc_pkg::CAP_IR;
            io_otc_pkg::CAP_IR: nxt_state = tmsIn ? io_otc_pkg::EX1_IR : io_otc_pkg::SH_IR;
            io_otc_pkg::SH_IR:  nxt_state = tmsIn ? io_otc_pkg::EX1_IR : io_otc_pkg::SH_IR;
            io_otc_pkg::EX1_IR: nxt_state = tmsIn ? io_otc_pkg::UPD_IR : io_otc_pkg::PAU_IR;
            io_otc_pkg::PAU_IR: nxt_state = tmsIn ? io_otc_pkg::EX2_IR : io_otc_pkg::PAU_IR;
            io_otc_pkg::EX2_IR: nxt_state = tmsIn ? io_otc_pkg::UPD_IR : io_otc_pkg::SH_IR;
            io_otc_pkg::UPD_IR: nxt_state = tmsIn ? io_otc_pkg::SEL_DR : io_otc_pkg::RTI;
            default:            nxt_state = io_otc_pkg::TLR;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            state_ff <= io_otc_pkg::TLR;
        else if (ce && rise)
            state_ff <= nxt_state;
    end

    // Instruction register, bypass after logic reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irShift_ff <= io_otc_pkg::INS_BYPASS;
            ir_ff      <= io_otc_pkg::INS_BYPASS;
        end
        else if (ce && state_ff == io_otc_pkg::TLR)
            ir_ff <= io_otc_pkg::INS_BYPASS;
        else if (ce && rise)
        begin
            if (state_ff == io_otc_pkg::CAP_IR)
                irShift_ff <= io_otc_pkg::IR_CAPTURE_VAL;
            else if (state_ff == io_otc_pkg::SH_IR)
                irShift_ff <= {tdiIn, irShift_ff[2:1]};
            else if (state_ff == io_otc_pkg::UPD_IR)
                ir_ff <= irShift_ff;
        end
    end

    assign tapCtl.tckRise   = rise;
    assign tapCtl.tckFall   = ~tckIn & tckPrev_ff;
    assign tapCtl.captureDr = state_ff == io_otc_pkg::CAP_DR;
    assign tapCtl.shiftDr   = state_ff == io_otc_pkg::SH_DR;
    assign tapCtl.updateDr  = state_ff == io_otc_pkg::UPD_DR;
    assign tapCtl.shiftIr   = state_ff == io_otc_pkg::SH_IR;
    assign tapCtl.instr     = ir_ff;
    assign tapCtl.irTdo     = irShift_ff[0];

    AST_IR_RESET: assert property (@(posedge mclk) disable iff (rst)
        (ce && state_ff == io_otc_pkg::TLR) |=> ir_ff == io_otc_pkg::INS_BYPASS)
        else $error("instruction not bypass after logic reset");

endmodule

`default_nettype wire

// File: verif/pad_partner.sv
// Pad-side model: external parts and pull-ups on every pad
`timescale 1ns/1ps
`default_nettype none

module pad_partner
#(
    parameter int N = 8
)
(
    // Design pad drive
    input  wire logic [N-1:0] padOut,
    input  wire logic [N-1:0] padOe,
    // External driver
    input  wire logic [N-1:0] extOe,
    input  wire logic [N-1:0] extVal,
    // Resolved pad level
    output logic [N-1:0]      padLvl
);
    // Floated pad is pulled up unless an external part drives it
    always_comb
        for (int i = 0; i < N; i++)
            padLvl[i] = padOe[i] ? padOut[i] : (extOe[i] ? extVal[i] : 1'b1);
endmodule

`default_nettype wire

// File: verif/io_output_tristate_control_tb.sv
// Self-checking bench for the I/O output path and test port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samplesChecked++; \
        if ((got) !== (ex)) \
        begin \
            failCount++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
        end \
    end

module io_output_tristate_control_tb;
    localparam int N = 8;
    logic         mclk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, dout, pat;
    logic [N-1:0] userOut = '0, userHiz = '0, extOe = '0, extVal = '0, got;
    logic [N-1:0] padLvl, padOut, padOe, padFast;
    logic         hizNetPin = 1'b0, hizNetNode = 1'b0;
    logic         tckPin = 1'b0, tmsPin = 1'b1, tdiPin = 1'b0;
    logic         userTdo1 = 1'b1, userTdo2 = 1'b0, tdoPin, tdoOe, user1Sel, user2Sel, userShift;
    logic [7:0]   rows [5] = '{8'hC5, 8'hE4, 8'hE1, 8'h87, 8'h84};
    logic [15:0]  pats [4] = '{16'h0000, 16'h25BC, 16'h7FFF, 16'h5A81};
    int           failCount = 0, samplesChecked = 0, cycles = 0, shifts = 0, n;

    always #25 mclk = ~mclk;

    io_output_tristate_control #(.NUM_CELLS(N)) DUT (
        .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .userOut(userOut), .userHiz(userHiz), .padIn(padLvl), .padOut(padOut), .padOe(padOe),
        .padFast(padFast), .hizNetPin(hizNetPin), .hizNetNode(hizNetNode), .tckPin(tckPin),
        .tmsPin(tmsPin), .tdiPin(tdiPin), .tdoPin(tdoPin), .tdoOe(tdoOe),
        .userTdo1(userTdo1), .userTdo2(userTdo2), .user1Sel(user1Sel),
        .user2Sel(user2Sel), .userShift(userShift));

    pad_partner #(.N(N)) partner (.padOut(padOut), .padOe(padOe), .extOe(extOe),
        .extVal(extVal), .padLvl(padLvl));

    always @(posedge mclk)
    begin
        cycles++;
        if (userShift === 1'b1)
            shifts++;
        if (cycles == 30000)
        begin
            failCount++;
            finishTest();
        end
    end

    task automatic finishTest();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic waitc(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic exErr);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        `CHK("pslverr", exErr, pslverr)
        if (!w)
            `CHK("prdata", ex, prdata)
    endtask

    task automatic tck(input logic ms, input logic di, output logic b);
        @(posedge mclk);
        tckPin <= 1'b0;
        tmsPin <= ms;
        tdiPin <= di;
        repeat (4) @(posedge mclk);
        b = tdoPin;
        tckPin <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic scan(input logic ir, input int nb, input logic [31:0] din);
        logic b;
        dout = '0;
        tck(1'b1, 1'b0, b);
        if (ir)
            tck(1'b1, 1'b0, b);
        tck(1'b0, 1'b0, b);
        tck(1'b0, 1'b0, b);
        for (int i = 0; i < nb; i++)
        begin
            tck(i == nb - 1, din[i], b);
            dout[i] = b;
        end
        tck(1'b1, 1'b0, b);
        tck(1'b0, 1'b0, b);
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        waitc(1);
        `CHK("padOe", 8'h00, padOe)
        `CHK("padFast", 8'h00, padFast)
        `CHK("tdoOe", 1'b0, tdoOe)
        acc(1'b0, io_otc_pkg::STATUS_OFS, 32'h0, 32'h70, 1'b0);
        acc(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
        acc(1'b1, io_otc_pkg::STATUS_OFS, 32'h1, 32'h0, 1'b1);
        $display("test reset done");
        acc(1'b1, io_otc_pkg::OUT_INV_OFS, 32'h0F, 32'h0, 1'b0);
        acc(1'b1, io_otc_pkg::HIZ_INV_OFS, 32'h33, 32'h0, 1'b0);
        acc(1'b1, io_otc_pkg::FAST_OFS, 32'h81, 32'h0, 1'b0);
        acc(1'b0, io_otc_pkg::FAST_OFS, 32'h0, 32'h81, 1'b0);
        acc(1'b1, io_otc_pkg::CTRL_OFS, 32'h8, 32'h0, 1'b0);
        n = 0;
        while (padOe === 8'h00 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        `CHK("padOe", 8'hCC, padOe)
        `CHK("padFast", 8'h00, padFast)
        @(negedge mclk);
        `CHK("padFast", 8'h81, padFast)
        $display("test softstart done");
        foreach (pats[i])
        begin
            @(posedge mclk);
            userOut <= pats[i][15:8];
            userHiz <= pats[i][7:0];
            waitc(2);
            `CHK("padOut", pats[i][15:8] ^ 8'h0F, padOut)
            `CHK("padOe", ~(pats[i][7:0] ^ 8'h33), padOe)
            `CHK("padLvl", pats[i][7], padLvl[7])
        end
        @(posedge mclk);
        ce      <= 1'b0;
        userOut <= 8'hFF;
        waitc(2);
        `CHK("padOutFrozen", 8'h55, padOut)
        @(posedge mclk);
        ce <= 1'b1;
        waitc(1);
        `CHK("padOutResumed", 8'hF0, padOut)
        $display("test polarity done");
        @(posedge mclk);
        userHiz <= 8'h00;
        foreach (rows[i])
        begin
            @(posedge mclk);
            hizNetPin  <= rows[i][2];
            hizNetNode <= rows[i][1];
            acc(1'b1, io_otc_pkg::CTRL_OFS, {28'h0, rows[i][7:4]}, 32'h0, 1'b0);
            waitc(2);
            `CHK("padOe", rows[i][0] ? 8'h00 : 8'hCC, padOe)
        end
        $display("test globalnet done");
        acc(1'b1, io_otc_pkg::CTRL_OFS, 32'h9, 32'h0, 1'b0);
        waitc(2);
        `CHK("tdoOe", 1'b1, tdoOe)
        tck(1'b0, 1'b0, dout[0]);
        scan(1'b1, 3, 32'h0);
        `CHK("irCapture", 3'h1, dout[2:0])
        acc(1'b0, io_otc_pkg::STATUS_OFS, 32'h0, 32'h07, 1'b0);
        @(posedge mclk);
        hizNetNode <= 1'b1;
        pat = '0;
        for (int i = 0; i < N; i++)
            pat[3*i +: 2] = 2'(i);
        scan(1'b0, 3 * N, pat);
        waitc(2);
        `CHK("padOe", 8'h55, padOe)
        `CHK("padOut", 8'hCC, padOut)
        scan(1'b1, 3, 32'h7);
        scan(1'b0, 9, 32'hB5);
        `CHK("bypass", 9'h16A, dout[8:0])
        `CHK("padOe", 8'h00, padOe)
        @(posedge mclk);
        extOe  <= 8'hFF;
        extVal <= 8'h5A;
        scan(1'b1, 3, 32'h1);
        scan(1'b0, 3 * N, 32'h0);
        for (int i = 0; i < N; i++)
            got[i] = dout[3*i+2];
        `CHK("sampleIn", 8'h5A, got)
        for (int k = 0; k < 2; k++)
        begin
            scan(1'b1, 3, 32'(2 + k));
            waitc(1);
            `CHK("userSel", k ? 2'h2 : 2'h1, {user2Sel, user1Sel})
            shifts = 0;
            scan(1'b0, 4, 32'h0);
            `CHK("userTdo", k ? 4'h0 : 4'hF, dout[3:0])
            `CHK("userShift", 4, shifts)
        end
        $display("test scan done");
        finishTest();
    end
endmodule

`default_nettype wire
